//--- common/spf_pkg.sv
// Purpose: Shared constants and types of the serial flash program control.
// Assumes: Array of 256 kB split into 64 kB blocks, 20 MHz system clock.
// Notes:   Every opcode, width and timing count of the block lives here.
//
// Contract
// R01: Several bytes in one sequential cycle: only the last byte is programmed.
// R02: Sequential frame ending mid-byte or without a byte aborts, clears latch flag.
// R03: Sequential start address in protected block: no execution, clear latch flag.
// R04: Sequential mode exits after highest unprotected location, clears latch flag.
// R05: Host restarts sequential mode with opcode, address and first byte.
// R06: No sequential wrap: after last array address exit and clear latch.
// R07: Sequential address entering erase-suspended 64 kB block exits the mode.
// R08: Latch flag cleared during sequential programming exits sequential mode.
// R09: Dual page program writes 1..256 bytes only with latch flag set.
// R10: After dual opcode and address the data output pin becomes an input.
// R11: Opcode then 24-bit address shift in MSB first from bit 23.
// R12: Dual data: four clocks per byte, odd bit on output pin, even on input.
// R13: Data bytes go to page buffer, programmed at select release.
// R14: Unaligned start wraps within the same 256-byte page.
// R15: Under 256 bytes leave rest; over 256 keep the latest 256.
// R16: Address and a whole byte required, release on byte boundary, else abort.
// R17: Dual program on protected block: skip, go idle, clear latch flag.
// R18: Busy flag in first status register while self-timed programming runs.
// R19: Later sequential cycles carry opcode and one byte, programmed at counter.
// R20: Host ends sequential mode with write disable, clearing latch flag.
// R21: Sequential address counter advances by one after each programmed byte.

package spf_pkg;

  // Command opcodes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_SEQ_A  = 8'had;
  localparam logic [7:0] OP_SEQ_B  = 8'haf;
  localparam logic [7:0] OP_DUAL   = 8'ha2;

  // Frame geometry
  localparam int         CMD_BITS   = 8;
  localparam int         ADDR_BITS  = 24;
  localparam int         BYTE_BITS  = 8;
  localparam int         PAGE_BYTES = 256;
  localparam int         PAGE_AW    = 8;
  localparam logic [23:0] ARRAY_LAST = 24'h03ffff;
  localparam int         BLOCK_SHIFT = 16;
  localparam int         NUM_BLOCKS  = 4;

  // Status register bit positions
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_WLF_BIT  = 1;

  // Timing
  localparam int SYS_CLK_HZ         = 20_000_000;
  localparam int CLK_PERIOD_NS      = 1_000_000_000 / SYS_CLK_HZ;
  localparam int BYTE_PROG_TIME_NS  = 20_000;
  localparam int PAGE_PROG_TIME_NS  = 2_000_000;
  localparam int BYTE_PROG_CYC =
    (BYTE_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_PROG_CYC =
    (PAGE_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;

  // Output FIFO
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W     = ADDR_BITS + BYTE_BITS;

  // Frame phases
  typedef enum logic [2:0] {
    SPF_PH_CMD,
    SPF_PH_ADDR,
    SPF_PH_DATA,
    SPF_PH_STAT,
    SPF_PH_SKIP
  } spf_phase_t;

  // Program engine states
  typedef enum logic [1:0] {
    SPF_ENG_IDLE,
    SPF_ENG_FILL,
    SPF_ENG_WAIT
  } spf_eng_t;

endpackage

//--- logic/spf_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Full and empty are exact; a stalled drain backs up the source.
`timescale 1ns/1ps

module spf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output logic                  o_empty
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Handshakes
  assign o_in_ready  = (count_reg != DEPTH_C);
  assign o_out_valid = (count_reg != '0);
  assign o_empty     = (count_reg == '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg];

  // Storage
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

//--- logic/spf_program_ctrl.sv
// Purpose: Command, data and program control of sequential and dual page
//          programming, sampled from the serial link by the system clock.
// Assumes: Serial clock at most a quarter of the system clock, modes 0/3.
// Notes:   Array writes leave through a FIFO as address/data words.
`timescale 1ns/1ps

module spf_program_ctrl #(
  parameter int BYTE_PROG_CYC = spf_pkg::BYTE_PROG_CYC,
  parameter int PAGE_PROG_CYC = spf_pkg::PAGE_PROG_CYC,
  parameter int NUM_BLOCKS    = spf_pkg::NUM_BLOCKS
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_srst,
  input  wire logic                  i_cs_n,
  input  wire logic                  i_sck,
  input  wire logic                  i_si,
  input  wire logic                  i_so,
  output logic                       o_so,
  output logic                       o_so_oe,
  input  wire logic [NUM_BLOCKS-1:0] i_block_protect,
  input  wire logic [NUM_BLOCKS-1:0] i_erase_suspend,
  output logic                       o_wr_valid,
  input  wire logic                  i_wr_ready,
  output logic [23:0]                o_wr_addr,
  output logic [7:0]                 o_wr_data,
  output logic                       o_busy_flag,
  output logic                       o_write_latch_flag,
  output logic                       o_sequential_mode_flag
);

  localparam int BW = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;
  localparam logic [4:0] CMD_LAST  = 5'(spf_pkg::CMD_BITS - 1);
  localparam logic [4:0] ADDR_LAST = 5'(spf_pkg::ADDR_BITS - 1);
  localparam logic [8:0] PAGE_FULL = 9'(spf_pkg::PAGE_BYTES);
  localparam logic [spf_pkg::TIMER_W-1:0] BYTE_T =
    spf_pkg::TIMER_W'(BYTE_PROG_CYC);
  localparam logic [spf_pkg::TIMER_W-1:0] PAGE_T =
    spf_pkg::TIMER_W'(PAGE_PROG_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  ////////////////////////////////////////////////////////////////////////////

  logic cs_s1, cs_s2, cs_s3;
  logic sck_s1, sck_s2, sck_s3;
  logic si_s1, si_s2;
  logic so_s1, so_s2;
  logic sck_rise, sck_fall, cs_rise, frame_on;

  // Two flops per pin, third for edges
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      si_s1  <= 1'b0;
      si_s2  <= 1'b0;
      so_s1  <= 1'b0;
      so_s2  <= 1'b0;
    end else begin
      cs_s1  <= i_cs_n;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      sck_s1 <= i_sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1  <= i_si;
      si_s2  <= si_s1;
      so_s1  <= i_so;
      so_s2  <= so_s1;
    end
  end

  // Edge strobes
  assign frame_on = !cs_s2;
  assign sck_rise = frame_on && sck_s2 && !sck_s3;
  assign sck_fall = frame_on && !sck_s2 && sck_s3;
  assign cs_rise  = cs_s2 && !cs_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder
  ////////////////////////////////////////////////////////////////////////////

  spf_pkg::spf_phase_t phase_reg;
  logic [7:0]  cmd_reg;
  logic [4:0]  bit_cnt_reg;
  logic [23:0] addr_reg;
  logic        addr_done_reg;
  logic        is_seq_reg;
  logic        is_dual_reg;
  logic        cmd_done_reg;
  logic [7:0]  byte_sh_reg;
  logic [2:0]  data_bits_reg;
  logic [8:0]  byte_cnt_reg;
  logic [7:0]  wr_idx_reg;
  logic [7:0]  last_byte_reg;
  logic        wlf_reg;
  logic        seq_mode_reg;
  logic [23:0] seq_addr_reg;
  spf_pkg::spf_eng_t eng_reg;
  logic        busy;

  logic [7:0]  cmd_full;
  logic [2:0]  data_step;
  logic [7:0]  byte_full;
  logic        byte_done;
  logic        is_seq_op;

  // Next values of the shifters
  assign cmd_full  = {cmd_reg[6:0], si_s2};
  assign is_seq_op = (cmd_full == spf_pkg::OP_SEQ_A) ||
                     (cmd_full == spf_pkg::OP_SEQ_B);
  assign data_step = is_dual_reg ? 3'h2 : 3'h1;
  assign byte_full = is_dual_reg ? {byte_sh_reg[5:0], so_s2, si_s2} // [R12]
                                 : {byte_sh_reg[6:0], si_s2};
  assign byte_done = sck_rise && (phase_reg == spf_pkg::SPF_PH_DATA) &&
                     (3'(data_bits_reg + data_step) == 3'h0);

  // Phase walk over opcode, address and data
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !frame_on) begin
      phase_reg     <= spf_pkg::SPF_PH_CMD;
      cmd_reg       <= 8'h00;
      bit_cnt_reg   <= 5'h00;
      addr_done_reg <= 1'b0;
      is_seq_reg    <= 1'b0;
      is_dual_reg   <= 1'b0;
      cmd_done_reg  <= 1'b0;
      data_bits_reg <= 3'h0;
      byte_cnt_reg  <= 9'h000;
      if (i_srst) begin
        addr_reg      <= 24'h000000;
        byte_sh_reg   <= 8'h00;
        wr_idx_reg    <= 8'h00;
        last_byte_reg <= 8'h00;
      end
    end else if (sck_rise) begin
      unique case (phase_reg)
        spf_pkg::SPF_PH_CMD: begin
          cmd_reg     <= cmd_full; // [R11]
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == CMD_LAST) begin
            bit_cnt_reg  <= 5'h00;
            cmd_done_reg <= 1'b1;
            phase_reg    <= spf_pkg::SPF_PH_SKIP;
            if (cmd_full == spf_pkg::OP_RDSR) begin
              phase_reg <= spf_pkg::SPF_PH_STAT;
            end else if (busy) begin
              phase_reg <= spf_pkg::SPF_PH_SKIP;
            end else if (is_seq_op && seq_mode_reg) begin
              is_seq_reg <= 1'b1;
              phase_reg  <= spf_pkg::SPF_PH_DATA; // [R19]
            end else if (is_seq_op && wlf_reg) begin
              is_seq_reg <= 1'b1;
              phase_reg  <= spf_pkg::SPF_PH_ADDR;
            end else if (cmd_full == spf_pkg::OP_DUAL && wlf_reg &&
                         !seq_mode_reg) begin // [R09]
              is_dual_reg <= 1'b1;
              phase_reg   <= spf_pkg::SPF_PH_ADDR;
            end
          end
        end
        spf_pkg::SPF_PH_ADDR: begin
          addr_reg    <= {addr_reg[22:0], si_s2}; // [R11]
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
          if (bit_cnt_reg == ADDR_LAST) begin
            addr_done_reg <= 1'b1;
            wr_idx_reg    <= {addr_reg[6:0], si_s2}; // [R14]
            phase_reg     <= spf_pkg::SPF_PH_DATA;
          end
        end
        spf_pkg::SPF_PH_DATA: begin
          byte_sh_reg   <= byte_full;
          data_bits_reg <= 3'(data_bits_reg + data_step);
          if (byte_done) begin
            last_byte_reg <= byte_full; // [R01]
            wr_idx_reg    <= wr_idx_reg + 8'h01; // [R14]
            if (byte_cnt_reg != PAGE_FULL) begin
              byte_cnt_reg <= byte_cnt_reg + 9'h001; // [R15]
            end
          end
        end
        spf_pkg::SPF_PH_STAT,
        spf_pkg::SPF_PH_SKIP: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page buffer
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] page_mem [spf_pkg::PAGE_BYTES];

  // Dual bytes land at the running slot
  always_ff @(posedge i_clk_sys) begin
    if (byte_done && is_dual_reg) begin
      page_mem[wr_idx_reg] <= byte_full; // [R13] [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame end decisions
  ////////////////////////////////////////////////////////////////////////////

  logic [23:0]   tgt_addr;
  logic [BW-1:0] tgt_blk;
  logic          data_frame;
  logic          frame_good;
  logic          ev_prog;
  logic          ev_abort;
  logic          ev_wren;
  logic          ev_wrdi;
  logic          ev_done;
  logic          done_clear;
  logic          done_exit;

  assign tgt_addr   = addr_done_reg ? addr_reg : seq_addr_reg; // [R19]
  assign tgt_blk    = tgt_addr[spf_pkg::BLOCK_SHIFT +: BW];
  assign data_frame = cs_rise && (is_seq_reg || is_dual_reg) &&
                      (phase_reg == spf_pkg::SPF_PH_ADDR ||
                       phase_reg == spf_pkg::SPF_PH_DATA);
  assign frame_good = (phase_reg == spf_pkg::SPF_PH_DATA) &&
                      (byte_cnt_reg != 9'h000) &&
                      (data_bits_reg == 3'h0); // [R02] [R16]
  assign ev_prog    = data_frame && frame_good &&
                      !i_block_protect[tgt_blk]; // [R03] [R17]
  assign ev_abort   = data_frame && !ev_prog; // [R02] [R03] [R16] [R17]
  assign ev_wren    = cs_rise && cmd_done_reg && !busy &&
                      (phase_reg == spf_pkg::SPF_PH_SKIP) &&
                      (cmd_reg == spf_pkg::OP_WREN);
  assign ev_wrdi    = cs_rise && cmd_done_reg && !busy &&
                      (phase_reg == spf_pkg::SPF_PH_SKIP) &&
                      (cmd_reg == spf_pkg::OP_WRDI);

  ////////////////////////////////////////////////////////////////////////////
  // Write latch and sequential mode flags
  ////////////////////////////////////////////////////////////////////////////

  // Latch flag set and clear
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wlf_reg <= 1'b0;
    end else if (ev_wrdi || ev_abort || done_clear) begin
      wlf_reg <= 1'b0; // [R02] [R03] [R04] [R06] [R17]
    end else if (ev_wren) begin
      wlf_reg <= 1'b1;
    end
  end

  // Sequential mode follows the latch flag and the auto exits
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      seq_mode_reg <= 1'b0;
    end else if (!wlf_reg || done_exit || ev_abort) begin
      seq_mode_reg <= 1'b0; // [R08] [R07]
    end else if (ev_prog && is_seq_reg) begin
      seq_mode_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed program engine
  ////////////////////////////////////////////////////////////////////////////

  logic [23:0]               eng_addr_reg;
  logic [7:0]                eng_byte_reg;
  logic [8:0]                eng_cnt_reg;
  logic [8:0]                eng_idx_reg;
  logic                      eng_seq_reg;
  logic [spf_pkg::TIMER_W-1:0] timer_reg;
  logic [7:0]                slot;
  logic [23:0]               next_addr;
  logic [BW-1:0]             next_blk;
  logic                      fifo_in_valid;
  logic                      fifo_in_ready;
  logic                      fifo_empty;
  logic [spf_pkg::WORD_W-1:0] fifo_in_data;
  logic [spf_pkg::WORD_W-1:0] fifo_out_data;

  assign busy      = (eng_reg != spf_pkg::SPF_ENG_IDLE); // [R18]
  assign slot      = 8'(eng_addr_reg[7:0] + eng_idx_reg[7:0]); // [R14]
  assign next_addr = 24'(eng_addr_reg + 24'h000001); // [R21]
  assign next_blk  = next_addr[spf_pkg::BLOCK_SHIFT +: BW];
  assign fifo_in_valid = (eng_reg == spf_pkg::SPF_ENG_FILL) &&
                         (eng_idx_reg != eng_cnt_reg);
  assign fifo_in_data  = eng_seq_reg ?
    {eng_addr_reg, eng_byte_reg} :
    {eng_addr_reg[23:8], slot, page_mem[slot]}; // [R13]
  assign ev_done    = (eng_reg == spf_pkg::SPF_ENG_WAIT) &&
                      (timer_reg == '0);
  assign done_clear = ev_done && (!eng_seq_reg ||
                      eng_addr_reg == spf_pkg::ARRAY_LAST || // [R06]
                      i_block_protect[next_blk]); // [R04]
  assign done_exit  = ev_done && eng_seq_reg &&
                      i_erase_suspend[next_blk]; // [R07]

  // Start, drain into FIFO, wait timer
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      eng_reg      <= spf_pkg::SPF_ENG_IDLE;
      eng_addr_reg <= 24'h000000;
      eng_byte_reg <= 8'h00;
      eng_cnt_reg  <= 9'h000;
      eng_idx_reg  <= 9'h000;
      eng_seq_reg  <= 1'b0;
      timer_reg    <= '0;
    end else begin
      unique case (eng_reg)
        spf_pkg::SPF_ENG_IDLE: begin
          if (ev_prog) begin
            eng_reg      <= spf_pkg::SPF_ENG_FILL;
            eng_addr_reg <= tgt_addr;
            eng_byte_reg <= last_byte_reg; // [R01]
            eng_seq_reg  <= is_seq_reg;
            eng_cnt_reg  <= is_seq_reg ? 9'h001 : byte_cnt_reg; // [R15]
            eng_idx_reg  <= 9'h000;
          end
        end
        spf_pkg::SPF_ENG_FILL: begin
          if (fifo_in_valid && fifo_in_ready) begin
            eng_idx_reg <= eng_idx_reg + 9'h001;
          end
          if (!fifo_in_valid && fifo_empty) begin
            eng_reg   <= spf_pkg::SPF_ENG_WAIT;
            timer_reg <= eng_seq_reg ? BYTE_T : PAGE_T;
          end
        end
        spf_pkg::SPF_ENG_WAIT: begin
          if (timer_reg == '0) begin
            eng_reg <= spf_pkg::SPF_ENG_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // Sequential address counter
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      seq_addr_reg <= 24'h000000;
    end else if (ev_done && eng_seq_reg) begin
      seq_addr_reg <= next_addr; // [R21]
    end
  end

  // Array write FIFO
  spf_fifo #(
    .WIDTH (spf_pkg::WORD_W),
    .DEPTH (spf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_srst      (i_srst),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (fifo_out_data),
    .o_empty     (fifo_empty)
  );

  assign o_wr_addr = fifo_out_data[spf_pkg::WORD_W-1 -: spf_pkg::ADDR_BITS];
  assign o_wr_data = fifo_out_data[spf_pkg::BYTE_BITS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Status read-out on the data output pin
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] stat_sh_reg;
  logic [2:0] stat_cnt_reg;
  logic [7:0] stat_now;

  always_comb begin
    stat_now = 8'h00;
    stat_now[spf_pkg::STAT_BUSY_BIT] = busy; // [R18]
    stat_now[spf_pkg::STAT_WLF_BIT]  = wlf_reg;
  end

  // Status shifted out on falling clock
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !frame_on) begin
      o_so         <= 1'b0;
      o_so_oe      <= 1'b0;
      stat_sh_reg  <= 8'h00;
      stat_cnt_reg <= 3'h0;
    end else if (phase_reg != spf_pkg::SPF_PH_STAT) begin
      o_so_oe <= 1'b0; // [R10]
    end else if (sck_fall) begin
      o_so_oe      <= 1'b1;
      stat_cnt_reg <= stat_cnt_reg + 3'h1;
      if (stat_cnt_reg == 3'h0) begin
        o_so        <= stat_now[7];
        stat_sh_reg <= {stat_now[6:0], 1'b0};
      end else begin
        o_so        <= stat_sh_reg[7];
        stat_sh_reg <= {stat_sh_reg[6:0], 1'b0};
      end
    end
  end

  // Flag outputs
  assign o_busy_flag            = busy;
  assign o_write_latch_flag     = wlf_reg;
  assign o_sequential_mode_flag = seq_mode_reg;

endmodule

//--- tb/spf_program_ctrl_properties.sv
// Purpose: Port properties of the program control.
// Assumes: One clock, synchronous reset.
// Notes:   Bound into every spf_program_ctrl instance.
`timescale 1ns/1ps
module spf_program_ctrl_properties #(
  parameter int NUM_BLOCKS = 4
) (
  input wire logic                  i_clk_sys,
  input wire logic                  i_srst,
  input wire logic                  i_cs_n,
  input wire logic [NUM_BLOCKS-1:0] i_block_protect,
  input wire logic                  o_so_oe,
  input wire logic                  o_wr_valid,
  input wire logic                  i_wr_ready,
  input wire logic [23:0]           o_wr_addr,
  input wire logic [7:0]            o_wr_data,
  input wire logic                  o_busy_flag,
  input wire logic                  o_write_latch_flag,
  input wire logic                  o_sequential_mode_flag
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Named steps
  sequence s_stall;
    o_wr_valid && !i_wr_ready;
  endsequence
  sequence s_cs_quiet;
    i_cs_n [*5];
  endsequence
  ////////////////////////////////////////////////////////////////
  // Array writes
  AST_WR_HOLD: assert property (
    s_stall |=> o_wr_valid && $stable({o_wr_addr, o_wr_data}))
    else $error("word moved");
  AST_WR_PROT: assert property (
    o_wr_valid |-> !i_block_protect[o_wr_addr[17:16]])
    else $error("protected write");
  AST_WR_END: assert property (
    o_wr_valid |-> o_wr_addr <= 24'h03ffff)
    else $error("write past end");
  AST_WR_BUSY: assert property (
    o_wr_valid |-> o_busy_flag)
    else $error("write not busy");
  AST_BUSY_START: assert property (
    $rose(o_busy_flag) |-> i_cs_n && $past(i_cs_n, 3))
    else $error("busy in frame");
  // Flags
  AST_SEQ_LATCH: assert property (
    $fell(o_write_latch_flag) |=> !o_sequential_mode_flag)
    else $error("mode kept");
  AST_SEQ_ENTRY: assert property (
    $rose(o_sequential_mode_flag) |-> o_write_latch_flag && i_cs_n)
    else $error("bad mode entry");
  AST_SO_IN: assert property (
    s_cs_quiet |-> !o_so_oe)
    else $error("pin driven");
endmodule
bind spf_program_ctrl spf_program_ctrl_properties #(
  .NUM_BLOCKS(NUM_BLOCKS)
) props (
  .i_clk_sys, .i_srst, .i_cs_n, .i_block_protect, .o_so_oe, .o_wr_valid,
  .i_wr_ready, .o_wr_addr, .o_wr_data, .o_busy_flag, .o_write_latch_flag,
  .o_sequential_mode_flag
);

//--- tb/spf_host_model.sv
// Purpose: Host SPI model, mode 0.
// Assumes: Clock idles low between frames.
// Notes:   Released lines show the inverse.
`timescale 1ns/1ps
module spf_host_model (
  input  wire logic i_clk_sys,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  output logic      o_so
);
  // Idle levels
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
    o_so   = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic frame_begin();
    tick(1);
    o_cs_n <= 1'b0;
    tick(2);
  endtask
  // One serial clock
  task automatic bitx(input logic si, input logic so);
    tick(1);
    o_si  <= si;
    o_so  <= so;
    tick(3);
    o_sck <= 1'b1;
    tick(4);
    o_sck <= 1'b0;
  endtask
  task automatic byte1(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bitx(b[i], ~b[i]);
  endtask
  task automatic dual(input logic [7:0] b);
    for (int i = 3; i >= 0; i--) bitx(b[2*i], b[2*i+1]);
  endtask
  // Release lines
  task automatic frame_end();
    tick(2);
    o_cs_n <= 1'b1;
    o_si   <= ~o_si;
    o_so   <= ~o_so;
    tick(6);
  endtask
endmodule

//--- tb/spf_program_ctrl_tb.sv
// Purpose: Bench of the program control.
// Assumes: Short timers; block 1 protected.
// Notes:   Array writes queued as {addr, data}.
`timescale 1ns/1ps
module spf_program_ctrl_tb;
  logic        i_clk_sys, cs_n, sck, si, so, so_pin, o_so, o_so_oe;
  logic        i_srst = 1'b1;
  logic        i_wr_ready = 1'b1;
  logic [3:0]  i_block_protect = 4'h2;
  logic [3:0]  i_erase_suspend = 4'h0;
  logic        o_wr_valid, o_busy_flag, o_write_latch_flag;
  logic        o_sequential_mode_flag;
  logic [23:0] o_wr_addr;
  logic [7:0]  o_wr_data;
  logic [31:0] q[$];
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  assign so_pin = o_so_oe ? o_so : so;
  spf_host_model host (.i_clk_sys, .o_cs_n(cs_n), .o_sck(sck), .o_si(si),
    .o_so(so));
  spf_program_ctrl #(.BYTE_PROG_CYC(5), .PAGE_PROG_CYC(20)) uut (.i_clk_sys,
    .i_srst, .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_so(so_pin), .o_so,
    .o_so_oe, .i_block_protect, .i_erase_suspend, .o_wr_valid, .i_wr_ready,
    .o_wr_addr, .o_wr_data, .o_busy_flag, .o_write_latch_flag,
    .o_sequential_mode_flag);
  // Collect words, cut a hang short
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (o_wr_valid === 1'b1 && i_wr_ready)
      q.push_back({o_wr_addr, o_wr_data});
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic chk(input string s, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && o_busy_flag !== 1'b0; i++) host.tick(1);
    host.tick(2);
    chk("busy", o_busy_flag, 0);
  endtask
  task automatic hdr(input bit we, input logic [7:0] op, input logic [23:0] a);
    q.delete();
    if (we) begin
      host.frame_begin();
      host.byte1(8'h06);
      host.frame_end();
    end
    host.frame_begin();
    host.byte1(op);
    for (int i = 2; i >= 0; i--) host.byte1(a[8*i+:8]);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_dual_wrap();
    hdr(1, 8'ha2, 24'h0000fe);
    host.dual(8'h5a);
    host.dual(8'hc3);
    host.dual(8'h96);
    host.frame_end();
    wait_idle();
    chk("count", q.size(), 3);
    chk("w0", q[0], 32'h0000fe5a);
    chk("w1", q[1], 32'h0000ffc3);
    chk("w2", q[2], 32'h00000096);
    chk("latch", o_write_latch_flag, 0);
  endtask
  // Refused frames
  task automatic t_refused();
    for (int k = 0; k < 6; k++) begin
      hdr(k != 0, (k == 2 || k == 4) ? 8'had : 8'ha2,
          (k == 1 || k == 2) ? 24'h010000 : 24'h000000);
      if (k != 5) host.byte1(8'h44);
      if (k == 3 || k == 4) repeat (3) host.bitx(1'b1, 1'b0);
      host.frame_end();
      wait_idle();
      chk("words", q.size(), 0);
      chk("latch", o_write_latch_flag, 0);
      chk("seq", o_sequential_mode_flag, 0);
    end
  endtask
  task automatic t_seq();
    hdr(1, 8'had, 24'h00fffe);
    host.byte1(8'h12);
    host.byte1(8'h34);
    host.frame_end();
    chk("busy", o_busy_flag, 1);
    wait_idle();
    chk("seq", o_sequential_mode_flag, 1);
    host.frame_begin();
    host.byte1(8'haf);
    host.byte1(8'h56);
    host.frame_end();
    wait_idle();
    chk("w0", q[0], 32'h00fffe34);
    chk("w1", q[1], 32'h00ffff56);
    chk("latch", o_write_latch_flag, 0);
    chk("seq", o_sequential_mode_flag, 0);
  endtask
  // Array end, suspend, disable
  task automatic t_seq_end();
    for (int k = 0; k < 3; k++) begin
      i_erase_suspend <= (k == 1) ? 4'h8 : 4'h0;
      hdr(1, 8'had, k == 0 ? 24'h03ffff : 24'h02fffe + (k == 1));
      host.byte1(8'h78);
      host.frame_end();
      wait_idle();
      chk("latch", o_write_latch_flag, k != 0);
      chk("seq", o_sequential_mode_flag, k == 2);
    end
    host.frame_begin();
    host.byte1(8'h04);
    host.frame_end();
    chk("latch", o_write_latch_flag, 0);
    chk("seq", o_sequential_mode_flag, 0);
  endtask
  // Overlong stalled page
  task automatic t_page_full();
    i_wr_ready <= 1'b0;
    hdr(1, 8'ha2, 24'h000300);
    for (int k = 0; k < 258; k++) host.dual(k[7:0] ^ {8{k > 255}});
    host.frame_end();
    host.tick(40);
    chk("stall", o_wr_valid, 1);
    i_wr_ready <= 1'b1;
    wait_idle();
    chk("count", q.size(), 256);
    foreach (q[i])
      chk("slot", q[i], {16'h0003, i[7:0], i[7:0] ^ {8{i < 2}}});
  endtask
  initial begin
    host.tick(4);
    i_srst <= 1'b0;
    t_dual_wrap();
    t_refused();
    t_seq();
    t_seq_end();
    t_page_full();
    summarize();
  end
endmodule
